// ===== logic/gtp_pkg.sv
// constants and types for the parallel media-independent port.
// assumes one 100 MHz system clock; link pins are asynchronous.
//
// Summary of operation
// - speed_select picks mode; separate fields pick TBI clocking and MII side
// - GMII is full duplex only; transmit error pin is ignored
// - straps col=0 rxd=10 crs=0, or col=1 crs=0, give GMII
// - speed_select 10 with DDR bit clear gives GMII
// - collision output stays low in GMII
// - tx_pll_clock_out_en drives the transmit PLL clock on the TXCLK pin outside two-clock TBI
// - straps col=0 rxd=11 crs=0 give TBI
// - speed_select 11 with DDR bit clear gives TBI
// - TBI passes code-groups unchanged, no coding, no negotiation
// - partner drives transmit group; device captures it each tx clock rise
// - normal TBI drives two inverted half-rate receive clocks
// - receive group changes before each receive clock rise; comma on CRS changes on the same edge as the rise
// - primary clock marks odd groups; phase-1 clock on TXCLK marks even
// - rx_dv strap high or tbi_clock_scheme 1 selects two-clock TBI
// - one-clock TBI gives single receive clock, sampled on its rise
// - rx_dv strap low or tbi_clock_scheme 0 selects one-clock TBI
// - TBI receive pins carry bits 7..0, 8, 9 and comma on CRS
// - TBI transmit bits 7..0 from TXD, 8 from TX_EN, 9 from TX_ER
// - RTBI moves 10-bit codes over five wires on both clock edges
// - comma detection off holds the comma output low

package gtp_pkg;

    // ==========================================================
    // register port
    localparam int             DATA_W     = 16;
    localparam int             ADDR_W     = 4;
    localparam logic [3:0]     ADDR_CTRL  = 4'h0;
    localparam logic [3:0]     ADDR_PCS   = 4'h1;
    localparam logic [3:0]     ADDR_STAT  = 4'h2;

    // ==========================================================
    // field positions
    localparam int             CTL_SPD    = 0;
    localparam int             CTL_DDR    = 2;
    localparam int             CTL_TBICLK = 3;
    localparam int             CTL_SIDE   = 4;
    localparam int             CTL_TXCLK  = 5;
    localparam int             PCS_CDET   = 0;
    localparam int             STAT_MODE  = 10;
    localparam logic [15:0]    CTRL_RESET = 16'h0000;
    localparam logic [15:0]    PCS_RESET  = 16'h0001;
    localparam logic [1:0]     SPD_GMII   = 2'h2;
    localparam logic [1:0]     SPD_TBI    = 2'h3;

    // ==========================================================
    // timing: data stands this long before a receive clock rise
    localparam int             CLK_NS     = 10;
    localparam int             SETUP_NS   = 10;
    localparam int             SETUP_CYC  =
        (SETUP_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        GTP_GMII  = 2'b00,
        GTP_TBI   = 2'b01,
        GTP_RTBI  = 2'b10,
        GTP_OTHER = 2'b11
    } gtp_mode_type;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_RISE = 2'b01,
        RX_HIGH = 2'b10,
        RX_FALL = 2'b11
    } gtp_rx_state_type;

endpackage

// ===== logic/gtp_parallel_port.sv
// parallel port logic: mode select, GMII/TBI/RTBI transmit and receive.
// assumes serial side hands receive groups on the system clock.
`timescale 1ns/1ns
`default_nettype none

module gtp_parallel_port
    import gtp_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     reset_n,
    input  wire logic                     ce,
    input  wire logic [gtp_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [gtp_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                     reg_write,
    input  wire logic                     reg_read,
    output logic [gtp_pkg::DATA_W-1:0]    reg_rdata,
    input  wire logic                     strap_col,
    input  wire logic                     strap_crs,
    input  wire logic [1:0]               strap_rxd,
    input  wire logic                     strap_rx_dv,
    input  wire logic                     tx_clock_input,
    input  wire logic [7:0]               txd,
    input  wire logic                     tx_en,
    input  wire logic                     tx_er,
    input  wire logic                     tx_pll_clock,
    input  wire logic [9:0]               rx_group,
    input  wire logic                     rx_comma,
    input  wire logic                     rx_carrier,
    input  wire logic                     rx_group_valid,
    output logic [7:0]                    rxd,
    output logic                          rx_dv,
    output logic                          rx_er,
    output logic                          crs,
    output logic                          col,
    output logic                          rx_clock,
    output logic                          tx_clock_pin,
    output logic [9:0]                    tx_group,
    output logic                          tx_group_valid,
    output logic                          mii_side
);
    import gtp_pkg::*;

    // ==========================================================
    // synchronisers for every asynchronous pin
    localparam int SYNC_W = 17;
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic              clk_seen;
    logic              clk_fall;
    logic              tx_edge;
    logic              tx_fall;

    // no reset here: straps must be seen while reset is still held
    always_ff @(posedge clock) begin
        if (ce) begin
            sync1 <= {tx_pll_clock, strap_rx_dv, strap_rxd,
                      strap_crs, strap_col, tx_er, tx_en, txd,
                      tx_clock_input};
            sync2 <= sync1;
        end
    end

    // edge detect reads only the second stage and its delayed copy
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            clk_seen <= 1'b0;
        end else if (ce) begin
            clk_seen <= sync2[0];
        end
    end

    assign tx_edge  = sync2[0] & ~clk_seen;
    assign tx_fall  = ~sync2[0] & clk_seen;
    assign clk_fall = tx_fall;

    // ==========================================================
    // registers
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] pcs;
    logic              strap_done;
    logic [1:0]        strap_spd;
    gtp_mode_type      mode;
    logic              norm_tbi;

    // col high forces the gigabit GMII code whatever crs is
    assign strap_spd = sync2[11] ? SPD_GMII : sync2[14:13];

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ctrl       <= CTRL_RESET;
            pcs        <= PCS_RESET;
            strap_done <= 1'b0;
        end else if (ce) begin
            if (!strap_done) begin
                strap_done <= 1'b1;
                ctrl[CTL_SPD+:2] <= strap_spd;
                ctrl[CTL_DDR]    <= sync2[12];
                ctrl[CTL_TBICLK] <= sync2[15];
            end
            if (reg_write && reg_addr == ADDR_CTRL) begin
                ctrl <= reg_wdata;
            end
            if (reg_write && reg_addr == ADDR_PCS) begin
                pcs <= reg_wdata;
            end
        end
    end

    always_comb begin
        mode = GTP_OTHER;
        if (ctrl[CTL_DDR]) begin
            if (ctrl[CTL_SPD+:2] == SPD_TBI) begin
                mode = GTP_RTBI;
            end
        end else if (ctrl[CTL_SPD+:2] == SPD_GMII) begin
            mode = GTP_GMII;
        end else if (ctrl[CTL_SPD+:2] == SPD_TBI) begin
            mode = GTP_TBI;
        end
    end

    assign norm_tbi = (mode == GTP_TBI) && ctrl[CTL_TBICLK];

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            reg_rdata <= '0;
            mii_side  <= 1'b0;
        end else if (ce) begin
            mii_side  <= ctrl[CTL_SIDE];
            reg_rdata <= '0;
            if (reg_read) begin
                case (reg_addr)
                    ADDR_CTRL: reg_rdata <= ctrl;
                    ADDR_PCS:  reg_rdata <= pcs;
                    ADDR_STAT: reg_rdata <= {4'h0, mode, tx_group};
                    default:   reg_rdata <= '0;
                endcase
            end
        end
    end

    // ==========================================================
    // transmit capture
    logic [4:0] rtbi_low;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tx_group       <= '0;
            tx_group_valid <= 1'b0;
            rtbi_low       <= '0;
        end else if (ce) begin
            tx_group_valid <= 1'b0;
            if (tx_edge && mode == GTP_RTBI) begin
                rtbi_low <= sync2[5:1];
            end else if (clk_fall && mode == GTP_RTBI) begin
                tx_group       <= {sync2[5:1], rtbi_low};
                tx_group_valid <= 1'b1;
            end else if (tx_edge && mode == GTP_GMII) begin
                tx_group       <= {1'b0, sync2[9:1]};
                tx_group_valid <= 1'b1;
            end else if (tx_edge) begin
                tx_group       <= sync2[10:1];
                tx_group_valid <= 1'b1;
            end
        end
    end

    // ==========================================================
    // receive sequencer: data first, clock edge one cycle later
    gtp_rx_state_type rx_state;
    logic [9:0]       rx_hold;
    logic             odd_group;
    logic             comma_hold;
    logic             next_rx_clock;

    always_comb begin
        next_rx_clock = rx_clock;
        case (rx_state)
            RX_IDLE: begin
                if (rx_group_valid && !norm_tbi) begin
                    next_rx_clock = 1'b0;
                end else if (norm_tbi && odd_group) begin
                    // phase 0 must be low before an odd group can rise it
                    next_rx_clock = 1'b0;
                end
            end
            RX_RISE: begin
                next_rx_clock = norm_tbi ? odd_group : 1'b1;
            end
            RX_FALL: next_rx_clock = 1'b0;
            default: next_rx_clock = rx_clock;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rx_state     <= RX_IDLE;
            rx_hold      <= '0;
            odd_group    <= 1'b1;
            comma_hold   <= 1'b0;
            rxd          <= '0;
            rx_dv        <= 1'b0;
            rx_er        <= 1'b0;
            rx_clock     <= 1'b0;
            tx_clock_pin <= 1'b0;
        end else if (ce) begin
            rx_clock <= next_rx_clock;
            // phase-1 clock shares the TXCLK pin in two-clock TBI
            if (norm_tbi) begin
                tx_clock_pin <= ~next_rx_clock;
            end else begin
                tx_clock_pin <= ctrl[CTL_TXCLK] & sync2[16];
            end
            case (rx_state)
                RX_IDLE: begin
                    // a group offered while busy is dropped
                    if (rx_group_valid) begin
                        rx_hold    <= rx_group;
                        comma_hold <= rx_comma;
                        if (mode == GTP_RTBI) begin
                            rxd[4:0] <= rx_group[4:0];
                        end else begin
                            rxd   <= rx_group[7:0];
                            rx_dv <= rx_group[8];
                            rx_er <= rx_group[9];
                        end
                        rx_state <= RX_RISE;
                    end
                end
                RX_RISE: begin
                    // outside two-clock TBI the next group counts as odd
                    odd_group <= norm_tbi ? ~odd_group : 1'b1;
                    rx_state  <= (mode == GTP_RTBI) ? RX_HIGH : RX_IDLE;
                end
                RX_HIGH: begin
                    rxd[4:0] <= rx_hold[9:5];
                    rx_state <= RX_FALL;
                end
                RX_FALL: rx_state <= RX_IDLE;
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // comma on CRS in TBI and RTBI, carrier sense otherwise; col never rises
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            crs <= 1'b0;
            col <= 1'b0;
        end else if (ce) begin
            col <= 1'b0;
            if (mode == GTP_TBI || mode == GTP_RTBI) begin
                crs <= comma_hold & pcs[PCS_CDET];
            end else begin
                crs <= rx_carrier;
            end
        end
    end

    // ==========================================================
    // checks
    sequence s_load;
        ce && rx_state == RX_IDLE && rx_group_valid && !norm_tbi
            && mode != GTP_RTBI;
    endsequence

    sequence s_rise;
        s_load ##1 ce;
    endsequence

    property p_col_low;
        @(posedge clock) disable iff (!reset_n)
        ce |=> !col;
    endproperty
    a_col_low: assert property (p_col_low)
        else $error("collision output went high");

    property p_comma_off;
        @(posedge clock) disable iff (!reset_n)
        ce && mode == GTP_TBI && !pcs[PCS_CDET] |=> !crs;
    endproperty
    a_comma_off: assert property (p_comma_off)
        else $error("comma output high while detection off");

    property p_tx_pulse;
        @(posedge clock) disable iff (!reset_n)
        ce && tx_edge && mode == GTP_TBI |=> tx_group_valid ##1 !tx_group_valid;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse)
        else $error("no single capture pulse after tx clock rise");

    property p_tbi_pass;
        @(posedge clock) disable iff (!reset_n)
        ce && tx_edge && mode == GTP_TBI |=> tx_group == $past(sync2[10:1]);
    endproperty
    a_tbi_pass: assert property (p_tbi_pass)
        else $error("transmit group altered in TBI");

    property p_gmii_no_er;
        @(posedge clock) disable iff (!reset_n)
        ce && tx_edge && mode == GTP_GMII |=> !tx_group[9];
    endproperty
    a_gmii_no_er: assert property (p_gmii_no_er)
        else $error("transmit error leaked in GMII");

    property p_inverted;
        @(posedge clock) disable iff (!reset_n)
        ce && norm_tbi |=> rx_clock != tx_clock_pin;
    endproperty
    a_inverted: assert property (p_inverted)
        else $error("receive clocks not inverted");

    property p_data_then_edge;
        @(posedge clock) disable iff (!reset_n)
        s_rise |-> !rx_clock && rxd == $past(rx_group[7:0]) ##1 rx_clock;
    endproperty
    a_data_then_edge: assert property (p_data_then_edge)
        else $error("receive clock rose before data settled");

    property p_strap;
        @(posedge clock) disable iff (!reset_n)
        ce && !strap_done && !(reg_write && reg_addr == ADDR_CTRL)
            |=> ctrl[CTL_SPD+:2] == $past(strap_spd);
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap speed not latched");

    property p_mode_gmii;
        @(posedge clock) disable iff (!reset_n)
        ctrl[CTL_SPD+:2] == SPD_GMII && !ctrl[CTL_DDR] |-> mode == GTP_GMII;
    endproperty
    a_mode_gmii: assert property (p_mode_gmii)
        else $error("GMII not selected");

endmodule

`default_nettype wire

// ===== verif/gtp_mac_model.sv
// far-side model: the PCS or MAC that drives the transmit pins.
// assumes the bench toggles go once per code-group, 200 ns apart.
`timescale 1ns/1ns
`default_nettype none

module gtp_mac_model (
    input  wire logic       go,
    input  wire logic [9:0] group,
    output logic            tx_clock_input,
    output logic [7:0]      txd,
    output logic            tx_en,
    output logic            tx_er
);
    initial begin
        tx_clock_input = 1'b0;
        {tx_er, tx_en, txd} = 10'h000;
    end

    // one 125 ns clock period per group; the clock stands still between
    always @(go) begin
        {tx_er, tx_en, txd} = group;
        #62 tx_clock_input = 1'b1;
        #63 tx_clock_input = 1'b0;
        // released pins show the inverse so a stale group never passes
        #5 {tx_er, tx_en, txd} = ~group;
    end
endmodule

`default_nettype wire

// ===== verif/gtp_parallel_port_tb.sv
// self-checking bench for the parallel port, far side modelled.
// assumes the package and design files compile first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
  err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end

module gtp_parallel_port_tb
    import gtp_pkg::*;
;
    logic        clock, reset_n, ce, reg_write, reg_read;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, er;
    logic        s_col, s_crs, s_dv, tx_pll_clock, go;
    logic [1:0]  s_rxd;
    logic [9:0]  rx_group, grp, g, et;
    logic        rx_comma, rx_carrier, rx_group_valid;
    logic        rd_q, rxc_q, txp_q, rx_on, en_cd;
    logic [11:0] ex;
    logic [15:0] rq[$];
    logic [9:0]  tq[$];
    logic [11:0] xq[$];
    int          err_count, compares, i;
    wire logic [15:0] reg_rdata;
    wire logic [9:0]  tx_group;
    wire logic [7:0]  rxd, txd;
    wire logic   rx_dv, rx_er, crs, col, rx_clock, tx_clock_pin;
    wire logic   tx_group_valid, mii_side, tx_clock_input, tx_en, tx_er;

    gtp_parallel_port dut (.clock(clock), .reset_n(reset_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .strap_col(s_col), .strap_crs(s_crs), .strap_rxd(s_rxd),
        .strap_rx_dv(s_dv), .tx_clock_input(tx_clock_input), .txd(txd),
        .tx_en(tx_en), .tx_er(tx_er), .tx_pll_clock(tx_pll_clock),
        .rx_group(rx_group), .rx_comma(rx_comma), .rx_carrier(rx_carrier),
        .rx_group_valid(rx_group_valid), .rxd(rxd), .rx_dv(rx_dv),
        .rx_er(rx_er), .crs(crs), .col(col), .rx_clock(rx_clock),
        .tx_clock_pin(tx_clock_pin), .tx_group(tx_group),
        .tx_group_valid(tx_group_valid), .mii_side(mii_side));

    gtp_mac_model mac (.go(go), .group(grp),
        .tx_clock_input(tx_clock_input), .txd(txd), .tx_en(tx_en),
        .tx_er(tx_er));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ========
    // watcher: oldest note against each result
    always @(posedge clock) begin
        if (rd_q) begin
            er = rq.pop_front();
            `CHK("reg_rdata", er, reg_rdata)
        end
        if (tx_group_valid === 1'b1) begin
            et = tq.pop_front();
            `CHK("tx_group", et, tx_group)
        end
        if (rx_on && ((rx_clock && !rxc_q) || (tx_clock_pin && !txp_q)))
        begin
            ex = xq.pop_front();
            `CHK("rx pins", ex, {tx_clock_pin, crs, rx_er, rx_dv, rxd})
        end
        rd_q <= reg_read;
        rxc_q <= rx_clock;
        txp_q <= tx_clock_pin;
    end

    task automatic give_verdict;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        rq.push_back(e);
        @(posedge clock);
        reg_read <= 1'b0;
    endtask

    task automatic send_tx(input logic [9:0] v, input logic [9:0] e);
        grp <= v;
        go <= ~go;
        tq.push_back(e);
        repeat (20) @(posedge clock);
    endtask

    task automatic send_rx(input logic [9:0] v, input logic c,
                           input logic ph);
        @(posedge clock);
        rx_group <= v;
        rx_comma <= c;
        rx_group_valid <= 1'b1;
        xq.push_back({ph, c & en_cd, v});
        @(posedge clock);
        rx_group_valid <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    // straps packed as {col, crs, rxd[1:0], rx_dv}
    task automatic do_reset(input logic [4:0] st);
        @(posedge clock);
        reset_n <= 1'b0;
        {s_col, s_crs, s_rxd, s_dv} <= st;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
    endtask

    initial begin
        #200000;
        err_count++;
        give_verdict();
    end

    // ========
    // stimulus
    initial begin
        {reset_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
        {s_col, s_crs, s_rxd, s_dv, tx_pll_clock, go, grp} = '0;
        {rx_group, rx_comma, rx_carrier, rx_group_valid} = '0;
        {rd_q, rxc_q, txp_q, rx_on} = '0;
        ce = 1'b1;
        en_cd = 1'b1;
        err_count = 0;
        compares = 0;
        void'($urandom(32'h8A7C));
        do_reset(5'b00110);
        rd(ADDR_CTRL, 16'h0003);
        rd(ADDR_PCS, PCS_RESET);
        rd(4'h7, 16'h0000);
        for (i = 0; i < 3; i++) begin
            g = 10'($urandom);
            send_tx(g, g);
        end
        rd(ADDR_STAT, {6'h01, g});
        rx_on = 1'b1;
        for (i = 0; i < 4; i++)
            send_rx(10'($urandom), 1'($urandom), 1'b0);
        wr(ADDR_PCS, 16'h0000);
        en_cd = 1'b0;
        send_rx(10'($urandom), 1'b1, 1'b0);
        rx_on = 1'b0;
        wr(ADDR_PCS, 16'h0001);
        en_cd = 1'b1;
        wr(ADDR_CTRL, 16'h000B);
        repeat (4) @(posedge clock);
        rx_on = 1'b1;
        for (i = 0; i < 4; i++)
            send_rx(10'($urandom), 1'($urandom), i[0]);
        rx_on = 1'b0;
        wr(ADDR_CTRL, 16'h0012);
        rx_carrier <= 1'b1;
        tx_pll_clock <= 1'b1;
        g = 10'($urandom) | 10'h200;
        send_tx(g, {1'b0, g[8:0]});
        rd(ADDR_STAT, {7'h00, g[8:0]});
        `CHK("mii_side", 1'b1, mii_side)
        `CHK("col", 1'b0, col)
        `CHK("crs", 1'b1, crs)
        `CHK("tx_clock_pin", 1'b0, tx_clock_pin)
        wr(ADDR_CTRL, 16'h0032);
        repeat (5) @(posedge clock);
        `CHK("tx_clock_pin", 1'b1, tx_clock_pin)
        do_reset(5'b00100);
        rd(ADDR_CTRL, 16'h0002);
        do_reset(5'b10001);
        rd(ADDR_CTRL, 16'h000A);
        repeat (3) @(posedge clock);
        `CHK("pending", 32'd0, rq.size() + tq.size() + xq.size())
        give_verdict();
    end
endmodule

`default_nettype wire
